// file: bench/ebp_bus_checker_properties.sv
// pin function and bus cycle checker for the external bus port, with its bind
`timescale 1ns/1ps
module ebp_bus_checker (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        ext_bus_en_i,
  input wire logic [2:0]  bus_pin_control_register_i,
  input wire logic        acc_wr_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic        acc_busy_o,
  input wire logic        acc_done_o,
  input wire logic [7:0]  low_muxed_addr_data_pin_o,
  input wire logic [7:0]  low_muxed_addr_data_pin_oe_o,
  input wire logic [7:0]  upper_address_pin_o,
  input wire logic [7:0]  upper_address_pin_oe_o,
  input wire logic        buffer_control_out_pin_o,
  input wire logic        hold_grant_out_pin_o,
  input wire logic        hold_request_in_pin_i,
  input wire logic        hold_request_in_pin_oe_o,
  input wire logic        wait_release_in_pin_i,
  input wire logic        wait_release_in_pin_oe_o,
  input wire logic        bus_clock_out_pin_o,
  input wire logic        write_strobe_pin_n_o,
  input wire logic        write_strobe_pin_oe_o,
  input wire logic        read_strobe_pin_n_o,
  input wire logic        read_strobe_pin_oe_o
);
  wire       ext   = ext_bus_en_i;
  wire [2:0] bpc   = bus_pin_control_register_i;
  wire       gnt   = hold_grant_out_pin_o;
  wire       wr_n  = write_strobe_pin_n_o;
  wire       rd_n  = read_strobe_pin_n_o;
  wire [7:0] lo_oe = low_muxed_addr_data_pin_oe_o;
  wire [7:0] hi_oe = upper_address_pin_oe_o;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_start;
    ext && !gnt && $rose(acc_busy_o);
  endsequence
  a_dir_inputs:
    assert property ($past(arst_n_i && ext) |-> !wait_release_in_pin_oe_o
      && (!$past(bpc[2]) || !hold_request_in_pin_oe_o)) else $error("input pin driven");
  a_addr_phase:
    assert property (s_start |-> {upper_address_pin_o, low_muxed_addr_data_pin_o}
      == $past(acc_addr_i) && &hi_oe && &lo_oe) else $error("address phase wrong");
  a_write_strobe:
    assert property (s_start ##0 $past(acc_wr_i) |=> !wr_n [*2]) else $error("no write strobe");
  a_read_strobe:
    assert property (s_start ##0 !$past(acc_wr_i) |=> (!rd_n && lo_oe == 8'h00) [*2])
      else $error("no read strobe");
  a_buffer_strobe:
    assert property ($past(ext && bpc[0]) && ext && !gnt |-> buffer_control_out_pin_o
      == !(wr_n && rd_n)) else $error("buffer control wrong");
  a_ready_stretch:
    assert property (!wait_release_in_pin_i [*8] |-> !acc_done_o) else $error("done without ready");
  a_hold_float:
    assert property ($past(ext && bpc[1]) && gnt |-> !(|{lo_oe, hi_oe, write_strobe_pin_oe_o,
      read_strobe_pin_oe_o})) else $error("pins driven in hold");
  a_hold_release:
    assert property ($past(bpc[1]) && gnt && $fell(hold_request_in_pin_i) |-> ##[1:8] !gnt)
      else $error("grant not removed");
  a_bus_clock:
    assert property ($past(arst_n_i, 2) && ext && $past(ext) && $past(ext, 2)
      |-> bus_clock_out_pin_o != $past(bus_clock_out_pin_o)) else $error("bus clock stuck");
  c_write: cover property (s_start ##0 $past(acc_wr_i) ##[3:8] acc_done_o);
  c_hold: cover property ($rose(gnt));
  c_stretch: cover property (!wait_release_in_pin_i [*8] ##[1:20] acc_done_o);
endmodule // ebp_bus_checker

bind ebp_external_bus_port ebp_bus_checker u_ebp_bus_checker (.*);

// file: bench/ebp_ext_mem.sv
// external memory model on the multiplexed bus
`timescale 1ns/1ps
module ebp_ext_mem (
  input  wire logic       clk_i,
  input  wire logic [7:0] ad_i,
  input  wire logic [7:0] a_hi_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic [4:0] waits_i,
  output logic      [7:0] d_o,
  output logic      [7:0] d_oe_o,
  output logic            rdy_o
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q;
  logic [4:0]  cnt_q;
  always_ff @(posedge clk_i) begin
    if (wr_n_i && rd_n_i) begin
      addr_q <= {a_hi_i, ad_i};
      cnt_q  <= 5'h00;
    end else if (cnt_q != 5'h1f) begin
      cnt_q <= cnt_q + 5'h01;
    end
    if (!wr_n_i) mem[addr_q] <= ad_i;
  end
  // ready low between strobes, so stale data never pairs with ready
  assign rdy_o  = !(wr_n_i && rd_n_i) && cnt_q >= waits_i;
  assign d_oe_o = {8{!rd_n_i}};
  // byte is inverted until ready rises, so sampling ahead of ready reads wrong data
  assign d_o    = rdy_o ? mem[addr_q] : ~mem[addr_q];
endmodule // ebp_ext_mem

// file: bench/tb.sv
// self-checking bench for the external bus port
`timescale 1ns/1ps
module tb;
  import ebp_pkg::*;
  logic clk_i, arst_n_i, ext_bus_en_i, acc_req_i, acc_wr_i, acc_busy_o, acc_done_o;
  logic [2:0] bus_pin_control_register_i;
  logic [6:0] gp2_out_i;
  logic [15:0] acc_addr_i;
  logic [7:0] gp0_out_i, gp0_oe_i, gp1_out_i, gp1_oe_i, gp0_in_o, gp1_in_o;
  logic [7:0] acc_wdata_i, acc_rdata_o, park, m_d, m_oe;
  logic [7:0] low_muxed_addr_data_pin_i, low_muxed_addr_data_pin_o;
  logic [7:0] low_muxed_addr_data_pin_oe_o, upper_address_pin_i;
  logic [7:0] upper_address_pin_o, upper_address_pin_oe_o;
  logic buffer_control_out_pin_o, hold_grant_out_pin_o, bus_clock_out_pin_o;
  logic hold_request_in_pin_i, hold_request_in_pin_o, hold_request_in_pin_oe_o;
  logic wait_release_in_pin_i, wait_release_in_pin_o, wait_release_in_pin_oe_o;
  logic write_strobe_pin_n_o, write_strobe_pin_oe_o, read_strobe_pin_n_o;
  logic read_strobe_pin_oe_o, hreq, rdy, wr_l, rd_l;
  logic [4:0] waits;
  int errors, n_tests, cyc;
  // ---------------------------------------------------------------
  // pin resolution, released port lines take the memory byte or park, released control inputs take hreq and rdy
  // ---------------------------------------------------------------
  assign low_muxed_addr_data_pin_i = low_muxed_addr_data_pin_oe_o & low_muxed_addr_data_pin_o
    | ~low_muxed_addr_data_pin_oe_o & (m_oe & m_d | ~m_oe & park);
  assign upper_address_pin_i = upper_address_pin_oe_o & upper_address_pin_o
    | ~upper_address_pin_oe_o & park;
  assign hold_request_in_pin_i = hold_request_in_pin_oe_o ? hold_request_in_pin_o : hreq;
  assign wait_release_in_pin_i = wait_release_in_pin_oe_o ? wait_release_in_pin_o : rdy;
  assign wr_l = write_strobe_pin_oe_o ? write_strobe_pin_n_o : 1'b1;
  assign rd_l = read_strobe_pin_oe_o ? read_strobe_pin_n_o : 1'b1;
  ebp_external_bus_port u_ebp_external_bus_port (.*);
  ebp_ext_mem u_ebp_ext_mem (.clk_i(clk_i), .ad_i(low_muxed_addr_data_pin_i),
    .a_hi_i(upper_address_pin_i), .wr_n_i(wr_l), .rd_n_i(rd_l), .waits_i(waits),
    .d_o(m_d), .d_oe_o(m_oe), .rdy_o(rdy));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    acc_req_i = 1'b1;
    acc_wr_i = w;
    acc_addr_i = a;
    acc_wdata_i = d;
    cyc = 0;
    do begin
      step(1);
      cyc++;
      // drop the request once only, so a following call is the sole driver in its step
      if (acc_req_i && acc_busy_o === 1'b1 && hold_grant_out_pin_o === 1'b0) acc_req_i = 1'b0;
    end while (acc_done_o !== 1'b1 && cyc < 200);
    chk("done", acc_done_o, 1'b1);
  endtask
  task automatic wait_grant(input logic v);
    cyc = 0;
    do begin
      step(1);
      cyc++;
    end while (hold_grant_out_pin_o !== v && cyc < 20);
    chk("grant", hold_grant_out_pin_o, v);
  endtask
  task final_report;
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    {arst_n_i, ext_bus_en_i, acc_req_i, acc_wr_i, hreq} = 5'h00;
    {bus_pin_control_register_i, acc_addr_i, acc_wdata_i, waits} = 32'h0;
    {gp0_out_i, gp0_oe_i, gp1_out_i, gp1_oe_i} = 32'ha50f96ff;
    gp2_out_i = 7'h75;
    park = 8'h3c;
    step(2);
    arst_n_i = 1'b1;
    step(8);
    chk("gp0", {low_muxed_addr_data_pin_oe_o, low_muxed_addr_data_pin_o}, 16'h0fa5);
    chk("gp1", {upper_address_pin_oe_o, upper_address_pin_o}, 16'hff96);
    chk("gp_in", {gp1_in_o, gp0_in_o}, 16'h9635);
    chk("gp_ctl", {read_strobe_pin_n_o, write_strobe_pin_n_o, bus_clock_out_pin_o,
      wait_release_in_pin_o, hold_request_in_pin_o, hold_grant_out_pin_o,
      buffer_control_out_pin_o}, 16'h0075);
    ext_bus_en_i = 1'b1;
    bus_pin_control_register_i = 3'h7;
    gp2_out_i = 7'h00;
    step(6);
    chk("dir", {hold_request_in_pin_oe_o, wait_release_in_pin_oe_o}, 2'h0);
    acc(1'b1, 16'h12a5, 8'h5a);
    acc(1'b1, 16'hfe01, 8'ha5);
    chk("mem0", u_ebp_ext_mem.mem[16'h12a5], 8'h5a);
    chk("mem1", u_ebp_ext_mem.mem[16'hfe01], 8'ha5);
    waits = 5'd12;
    acc(1'b0, 16'h12a5, 8'h00);
    chk("rd_slow", acc_rdata_o, 8'h5a);
    chk("stretch", cyc > 14, 1'b1);
    waits = 5'd0;
    acc(1'b0, 16'hfe01, 8'h00);
    chk("rd_fast", acc_rdata_o, 8'ha5);
    chk("fast", cyc < 15, 1'b1);
    hreq = 1'b1;
    wait_grant(1'b1);
    chk("float", |{low_muxed_addr_data_pin_oe_o, upper_address_pin_oe_o,
      write_strobe_pin_oe_o, read_strobe_pin_oe_o}, 1'b0);
    acc_req_i = 1'b1;
    repeat (10) begin
      step(1);
      chk("refused", acc_done_o, 1'b0);
    end
    hreq = 1'b0;
    wait_grant(1'b0);
    acc(1'b0, 16'h12a5, 8'h00);
    chk("rd_hold", acc_rdata_o, 8'h5a);
    bus_pin_control_register_i = 3'h0;
    gp2_out_i = 7'h07;
    step(4);
    chk("bpc_off", {hold_request_in_pin_oe_o, hold_request_in_pin_o, hold_grant_out_pin_o,
      buffer_control_out_pin_o}, 4'hf);
    final_report();
  end
endmodule // tb

// file: hw/ebp_external_bus_port.sv
// port function select and multiplexed external bus cycle engine
`timescale 1ns/1ps
module ebp_external_bus_port (
  input  wire logic                          clk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          ext_bus_en_i,
  input  wire logic [ebp_pkg::BPC_WIDTH-1:0] bus_pin_control_register_i,
  input  wire logic [ebp_pkg::PORT_W-1:0]    gp0_out_i,
  input  wire logic [ebp_pkg::PORT_W-1:0]    gp0_oe_i,
  input  wire logic [ebp_pkg::PORT_W-1:0]    gp1_out_i,
  input  wire logic [ebp_pkg::PORT_W-1:0]    gp1_oe_i,
  input  wire logic [ebp_pkg::CTRL_W-1:0]    gp2_out_i,
  output logic      [ebp_pkg::PORT_W-1:0]    gp0_in_o,
  output logic      [ebp_pkg::PORT_W-1:0]    gp1_in_o,
  input  wire logic                          acc_req_i,
  input  wire logic                          acc_wr_i,
  input  wire logic [ebp_pkg::ADDR_W-1:0]    acc_addr_i,
  input  wire logic [ebp_pkg::PORT_W-1:0]    acc_wdata_i,
  output logic                               acc_busy_o,
  output logic                               acc_done_o,
  output logic      [ebp_pkg::PORT_W-1:0]    acc_rdata_o,
  input  wire logic [ebp_pkg::PORT_W-1:0]    low_muxed_addr_data_pin_i,
  output logic      [ebp_pkg::PORT_W-1:0]    low_muxed_addr_data_pin_o,
  output logic      [ebp_pkg::PORT_W-1:0]    low_muxed_addr_data_pin_oe_o,
  input  wire logic [ebp_pkg::PORT_W-1:0]    upper_address_pin_i,
  output logic      [ebp_pkg::PORT_W-1:0]    upper_address_pin_o,
  output logic      [ebp_pkg::PORT_W-1:0]    upper_address_pin_oe_o,
  output logic                               buffer_control_out_pin_o,
  output logic                               hold_grant_out_pin_o,
  input  wire logic                          hold_request_in_pin_i,
  output logic                               hold_request_in_pin_o,
  output logic                               hold_request_in_pin_oe_o,
  input  wire logic                          wait_release_in_pin_i,
  output logic                               wait_release_in_pin_o,
  output logic                               wait_release_in_pin_oe_o,
  output logic                               bus_clock_out_pin_o,
  output logic                               write_strobe_pin_n_o,
  output logic                               write_strobe_pin_oe_o,
  output logic                               read_strobe_pin_n_o,
  output logic                               read_strobe_pin_oe_o
);
  import ebp_pkg::*;

  // ---------------------------------------------------------------
  // pin input synchronisation
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync_w;
  logic [PORT_W-1:0] lo_s;
  logic [PORT_W-1:0] hi_s;
  logic              hreq_s;
  logic              rdy_s;

  ebp_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .async_i  ({wait_release_in_pin_i, hold_request_in_pin_i,
                upper_address_pin_i, low_muxed_addr_data_pin_i}),
    .sync_o   (sync_w)
  );

  assign lo_s   = sync_w[PORT_W-1:0];
  assign hi_s   = sync_w[2*PORT_W-1:PORT_W];
  assign hreq_s = sync_w[2*PORT_W];
  assign rdy_s  = sync_w[2*PORT_W+1];

  // ---------------------------------------------------------------
  // state and output registers
  // ---------------------------------------------------------------
  ebp_state_t        state_q;
  ebp_state_t        state_d;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_d;
  logic              wr_q;
  logic              wr_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [PORT_W-1:0] wdata_q;
  logic [PORT_W-1:0] wdata_d;
  logic [PORT_W-1:0] rdata_q;
  logic [PORT_W-1:0] rdata_d;
  logic              done_q;
  logic              done_d;
  logic              busy_q;
  logic              busy_d;
  logic              bclk_q;
  logic              bclk_d;
  logic [PORT_W-1:0] lo_o_q;
  logic [PORT_W-1:0] lo_o_d;
  logic [PORT_W-1:0] lo_oe_q;
  logic [PORT_W-1:0] lo_oe_d;
  logic [PORT_W-1:0] hi_o_q;
  logic [PORT_W-1:0] hi_o_d;
  logic [PORT_W-1:0] hi_oe_q;
  logic [PORT_W-1:0] hi_oe_d;
  logic [CTRL_W-1:0] ctl_o_q;
  logic [CTRL_W-1:0] ctl_o_d;
  logic [CTRL_W-1:0] ctl_oe_q;
  logic [CTRL_W-1:0] ctl_oe_d;

  logic hold_en;
  logic data_phase;
  logic held;
  assign hold_en = ext_bus_en_i && bus_pin_control_register_i[BPC_HREQ_BIT];

  // ---------------------------------------------------------------
  // next-state and pin function selection
  // ---------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    wr_d       = wr_q;
    addr_d     = addr_q;
    wdata_d    = wdata_q;
    rdata_d    = rdata_q;
    done_d     = 1'b0;
    data_phase = 1'b0;
    held       = 1'b0;

    case (state_q)
      ST_IDLE: begin
        if (hold_en && hreq_s) begin
          state_d = ST_HOLD;                                   // [RQ6]
        end else if (ext_bus_en_i && acc_req_i) begin
          state_d = ST_ADDR;
          wr_d    = acc_wr_i;
          addr_d  = acc_addr_i;
          wdata_d = acc_wdata_i;
        end
      end
      ST_ADDR: begin
        state_d = ST_STROBE;
        cnt_d   = 2'h0;
      end
      ST_STROBE: begin
        if (cnt_q != STROBE_MIN - 2'h1) begin
          cnt_d = cnt_q + 2'h1;
        end else if (rdy_s) begin                              // [RQ7] [RQ11]
          state_d = ST_END;
          done_d  = 1'b1;
          if (!wr_q) begin
            rdata_d = lo_s;                                    // [RQ2]
          end
        end
      end
      ST_END: begin
        state_d = ST_IDLE;
      end
      ST_HOLD: begin
        // grant falls once the request is gone or hold_en drops
        if (!(hold_en && hreq_s)) begin
          state_d = ST_IDLE;                                   // [RQ12]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    busy_d     = (state_d != ST_IDLE);
    data_phase = (state_d == ST_STROBE) || (state_d == ST_END);
    held       = (state_d == ST_HOLD);
    // free-running divide-by-two bus clock while the bus is on
    bclk_d     = ext_bus_en_i ? ~bclk_q : 1'b0;                // [RQ8]

    if (ext_bus_en_i) begin
      lo_o_d  = (data_phase && wr_d) ? wdata_d : addr_d[PORT_W-1:0];    // [RQ2]
      lo_oe_d = (held || (data_phase && !wr_d)) ? '0 : '1;              // [RQ2] [RQ12]
      hi_o_d  = addr_d[ADDR_W-1:PORT_W];                                // [RQ3]
      hi_oe_d = held ? '0 : '1;                                         // [RQ3] [RQ12]
    end else begin
      lo_o_d  = gp0_out_i;                                     // [RQ1]
      lo_oe_d = gp0_oe_i;                                      // [RQ1]
      hi_o_d  = gp1_out_i;                                     // [RQ1]
      hi_oe_d = gp1_oe_i;                                      // [RQ1]
    end

    ctl_o_d  = gp2_out_i;
    ctl_oe_d = '1;
    if (ext_bus_en_i) begin
      if (bus_pin_control_register_i[BPC_BUFFER_CONTROL_BIT]) begin
        ctl_o_d[0] = (state_d == ST_STROBE);                   // [RQ4]
      end
      if (bus_pin_control_register_i[BPC_HOLD_BIT]) begin
        ctl_o_d[1] = held;                                     // [RQ5] [RQ12]
      end
      if (bus_pin_control_register_i[BPC_HREQ_BIT]) begin
        ctl_o_d[2]  = 1'b0;
        ctl_oe_d[2] = 1'b0;                                    // [RQ6]
      end
      ctl_o_d[3]  = 1'b0;
      ctl_oe_d[3] = 1'b0;                                      // [RQ7]
      ctl_o_d[4]  = bclk_d;                                    // [RQ8]
      ctl_o_d[5]  = !((state_d == ST_STROBE) && wr_d);         // [RQ9]
      ctl_oe_d[5] = !held;                                     // [RQ12]
      ctl_o_d[6]  = !((state_d == ST_STROBE) && !wr_d);        // [RQ10]
      ctl_oe_d[6] = !held;                                     // [RQ12]
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 2'h0;
      wr_q     <= 1'b0;
      addr_q   <= ADDR_RST;
      wdata_q  <= DATA_RST;
      rdata_q  <= DATA_RST;
      done_q   <= 1'b0;
      busy_q   <= 1'b0;
      bclk_q   <= 1'b0;
      lo_o_q   <= DATA_RST;
      lo_oe_q  <= DATA_RST;
      hi_o_q   <= DATA_RST;
      hi_oe_q  <= DATA_RST;
      ctl_o_q  <= CTL_O_RST;
      ctl_oe_q <= CTL_OE_RST;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      wr_q     <= wr_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      rdata_q  <= rdata_d;
      done_q   <= done_d;
      busy_q   <= busy_d;
      bclk_q   <= bclk_d;
      lo_o_q   <= lo_o_d;
      lo_oe_q  <= lo_oe_d;
      hi_o_q   <= hi_o_d;
      hi_oe_q  <= hi_oe_d;
      ctl_o_q  <= ctl_o_d;
      ctl_oe_q <= ctl_oe_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign gp0_in_o                     = lo_s;
  assign gp1_in_o                     = hi_s;
  assign acc_busy_o                   = busy_q;
  assign acc_done_o                   = done_q;
  assign acc_rdata_o                  = rdata_q;
  assign low_muxed_addr_data_pin_o    = lo_o_q;
  assign low_muxed_addr_data_pin_oe_o = lo_oe_q;
  assign upper_address_pin_o          = hi_o_q;
  assign upper_address_pin_oe_o       = hi_oe_q;
  assign buffer_control_out_pin_o     = ctl_o_q[0];
  assign hold_grant_out_pin_o         = ctl_o_q[1];
  assign hold_request_in_pin_o        = ctl_o_q[2];
  assign hold_request_in_pin_oe_o     = ctl_oe_q[2];
  assign wait_release_in_pin_o        = ctl_o_q[3];
  assign wait_release_in_pin_oe_o     = ctl_oe_q[3];
  assign bus_clock_out_pin_o          = ctl_o_q[4];
  assign write_strobe_pin_n_o         = ctl_o_q[5];
  assign write_strobe_pin_oe_o        = ctl_oe_q[5];
  assign read_strobe_pin_n_o          = ctl_o_q[6];
  assign read_strobe_pin_oe_o         = ctl_oe_q[6];

endmodule // ebp_external_bus_port

// file: hw/ebp_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ebp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // a bit only moves once stages two and three agree
  always_comb begin
    out_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= async_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_o = out_q;

endmodule // ebp_sync

// file: shared/ebp_pkg.sv
// shared constants and types of the external bus port function select
// Summary of operation
// RQ1: bus off: both address ports are plain software-driven bidirectional port pins.
// RQ2: bus on: low port drives low address, then carries data both ways.
// RQ3: bus on: second port drives the upper address byte.
// RQ4: bus on and control bit set: first pin drives buffer control.
// RQ5: bus on and control bit set: second pin drives hold grant.
// RQ6: bus on and control bit set: third pin is sampled hold request input.
// RQ7: bus on: fourth pin is a ready input sampled during accesses.
// RQ8: bus on: fifth pin outputs the bus clock.
// RQ9: bus on: sixth pin drives active-low write strobe in write cycles.
// RQ10: bus on: seventh pin drives active-low read strobe in read cycles.
// RQ11: ready held low stretches the bus cycle until ready is high.
// RQ12: while hold granted, bus pins float until request drops, then grant ends.
package ebp_pkg;

  // ---------------------------------------------------------------
  // bus pin control register bit positions
  // ---------------------------------------------------------------
  localparam int unsigned BPC_WIDTH    = 3;
  localparam int unsigned BPC_BUFFER_CONTROL_BIT = 0;
  localparam int unsigned BPC_HOLD_BIT = 1;
  localparam int unsigned BPC_HREQ_BIT = 2;

  // ---------------------------------------------------------------
  // widths, reset values and timing counts
  // ---------------------------------------------------------------
  localparam int unsigned PORT_W       = 8;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned CTRL_W       = 7;
  localparam int unsigned SYNC_W       = 2 * PORT_W + 2;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [15:0] ADDR_RST     = 16'h0000;
  localparam logic [1:0]  STROBE_MIN   = 2'h2;
  localparam logic [6:0]  CTL_O_RST    = 7'h7f;
  localparam logic [6:0]  CTL_OE_RST   = 7'h00;

  // ---------------------------------------------------------------
  // bus cycle states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_STROBE,
    ST_END,
    ST_HOLD
  } ebp_state_t;

endpackage
